// File: logic/spsc_regs.sv
// Purpose: Port one link state and port two upper control register bank.
// Assumes: Link status pins come from the PHY domain and are synchronised here.
// Notes:   Read data stands one cycle after the read strobe and only then.
//
// Overview of operation
// - Bit 15 selects crossover algorithm, resets one.
// - Bit 13 reports reversed receive polarity.
// - Bit 12 reports transmit pause activity.
// - Bit 11 reports receive pause activity.
// - Bit 10 reports speed: one means 100M.
// - Bit 9 reports duplex: one means full.
// - Bit 8 reports far-end fault in fiber.
// - Bit 7 reports crossover state MDI-X.
// - Bit 6 reports auto-negotiation complete.
// - Bit 5 reports link good.
// - Bits 4..0 report partner advertised abilities.
// - Range after status word maps nothing.
// - Bits 14..12 force indicators or leave normal.
// - Bit 11 enables second address filter.
// - Bit 10 enables first address filter.
// - Bit 9 drops VLAN-tagged ingress frames.
// - Control bit 15 reserved, reads zero.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module spsc_regs #(
   parameter int ADDR_W = spsc_pkg::ADDR_W,
   parameter int DATA_W = spsc_pkg::DATA_W
) (
   // Clock and reset.
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   // Register port.
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   // Link status pins from the PHY and MAC.
   input  wire logic              polarity_rev_i,
   input  wire logic              tx_pause_act_i,
   input  wire logic              rx_pause_act_i,
   input  wire logic              speed_100_i,
   input  wire logic              full_duplex_i,
   input  wire logic              far_fault_i,
   input  wire logic              mdix_state_i,
   input  wire logic              an_done_i,
   input  wire logic              link_good_i,
   input  wire logic [4:0]        partner_abil_i,
   // Normal indicator drive from the LED mode logic.
   input  wire logic              normal_ind_zero_i,
   input  wire logic              normal_ind_one_i,
   // Control outputs.
   output logic                   crossover_algorithm_select_o,
   output logic                   port_indicator_zero_o,
   output logic                   port_indicator_one_o,
   output logic                   sa_filter_second_en_o,
   output logic                   sa_filter_first_en_o,
   output logic                   drop_tagged_o,
   // Interrupt.
   output logic                   irq_o
);

   localparam int NSTAT = 14;   // Synchronised status bits, 13 down to 0.
   localparam int NEV   = spsc_pkg::EV_COUNT;

   // Synchronised view of the status pins.
   logic [NSTAT-1:0] stat_raw;
   logic [NSTAT-1:0] stat_sync;
   logic [NSTAT-1:0] stat_prev_reg;   // Previous sample for edge events.

   // Software state.
   logic             xover_reg;        // Crossover algorithm select.
   logic [2:0]       led_code_reg;     // Indicator override code.
   logic             sa_second_reg;    // Second filter address enable.
   logic             sa_first_reg;     // First filter address enable.
   logic             drop_tag_reg;     // Drop tagged frames.
   logic [NEV-1:0]   irq_stat_reg;     // Sticky event bits.
   logic [NEV-1:0]   irq_en_reg;       // Event enables.
   logic [NEV-1:0]   irq_stat_next;
   logic [DATA_W-1:0] rdata_next;

   // Pack the pins so bit n of this vector is bit n of the status word.
   assign stat_raw = {polarity_rev_i, tx_pause_act_i, rx_pause_act_i, speed_100_i,
                      full_duplex_i, far_fault_i, mdix_state_i, an_done_i,
                      link_good_i, partner_abil_i};

   // Pins come from the PHY domain and are resynchronised first.
   spsc_sync #(
      .WIDTH (NSTAT)
   ) u_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i (stat_raw),
      .sync_o  (stat_sync)
   );

   // Address decode.
   // Decode is a full compare, so aliases of the two words read zero.
   wire hit_state   = (addr_i == spsc_pkg::OFS_LINK_STATE);
   wire hit_ctrl    = (addr_i == spsc_pkg::OFS_CONTROL_FIRST);
   wire hit_istat   = (addr_i == spsc_pkg::OFS_IRQ_STATUS);
   wire hit_ien     = (addr_i == spsc_pkg::OFS_IRQ_ENABLE);
   wire hit_iclr    = (addr_i == spsc_pkg::OFS_IRQ_CLEAR);
   wire wr_state    = wr_i && hit_state;
   wire wr_ctrl     = wr_i && hit_ctrl;
   wire wr_ien      = wr_i && hit_ien;
   wire wr_iclr     = wr_i && hit_iclr;

   // Assembled link state word; only bit 15 is stored by software.
   wire [DATA_W-1:0] link_word = {xover_reg, 1'b0, stat_sync};

   // Control word: bit 15 is tied to zero, bits 8..0 live elsewhere.
   wire [DATA_W-1:0] ctrl_word = {1'b0, led_code_reg, sa_second_reg, sa_first_reg,
                                  drop_tag_reg, 9'h000};

   // Read select; unmapped addresses, reserved range included, read zero.
   // Reading has no side effect, so software may poll any word freely.
   // The clear register is write-only and so falls through to zero.
   assign rdata_next = hit_state ? link_word :
                       hit_ctrl  ? ctrl_word :
                       hit_istat ? {{(DATA_W-NEV){1'b0}}, irq_stat_reg} :
                       hit_ien   ? {{(DATA_W-NEV){1'b0}}, irq_en_reg} :
                                   {DATA_W{1'b0}};

   // Events: link change, negotiation done rising, far-end fault rising.
   // They are taken from the synchronised levels, so a pin glitch shorter
   // than a clock can be missed; that is accepted for slow status levels.
   wire [NEV-1:0] ev_now;
   assign ev_now[spsc_pkg::EV_LINK_CHANGE] = stat_sync[spsc_pkg::LS_LINK_GOOD]
                                             ^ stat_prev_reg[spsc_pkg::LS_LINK_GOOD];
   assign ev_now[spsc_pkg::EV_AN_DONE]     = stat_sync[spsc_pkg::LS_AN_DONE]
                                             & ~stat_prev_reg[spsc_pkg::LS_AN_DONE];
   assign ev_now[spsc_pkg::EV_FAR_FAULT]   = stat_sync[spsc_pkg::LS_FAR_FAULT]
                                             & ~stat_prev_reg[spsc_pkg::LS_FAR_FAULT];

   // A set in the same cycle as a clear wins, so no event is lost.
   assign irq_stat_next = (irq_stat_reg & ~(wr_iclr ? wdata_i[NEV-1:0] : {NEV{1'b0}})) | ev_now;

   // Indicator decode: top code bit low leaves the normal function.
   // The code is held in a flop, so a forced level lags a write by two edges.
   wire led_force = led_code_reg[2];
   wire ind0_next = led_force ? led_code_reg[0] : normal_ind_zero_i;
   wire ind1_next = led_force ? led_code_reg[1] : normal_ind_one_i;

   // Software writable control state.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         xover_reg     <= spsc_pkg::RST_XOVER_ALG;
         led_code_reg  <= spsc_pkg::RST_LED_CODE;
         sa_second_reg <= 1'b0;
         sa_first_reg  <= 1'b0;
         drop_tag_reg  <= 1'b0;
      end
      else
      begin
         // Only bit 15 of the status word is stored; the rest is dropped.
         if (wr_state)
         begin
            xover_reg <= wdata_i[spsc_pkg::LS_XOVER_ALG];
         end
         if (wr_ctrl)
         begin
            led_code_reg  <= wdata_i[spsc_pkg::CF_LED_HI:spsc_pkg::CF_LED_LO];
            sa_second_reg <= wdata_i[spsc_pkg::CF_SA_FILT_SECOND];
            sa_first_reg  <= wdata_i[spsc_pkg::CF_SA_FILT_FIRST];
            drop_tag_reg  <= wdata_i[spsc_pkg::CF_DROP_TAGGED];
         end
      end
   end

   // Interrupt state and the edge history.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         irq_stat_reg  <= '0;
         irq_en_reg    <= '0;
         stat_prev_reg <= '0;
      end
      else
      begin
         irq_stat_reg  <= irq_stat_next;
         stat_prev_reg <= stat_sync;
         if (wr_ien)
         begin
            irq_en_reg <= wdata_i[NEV-1:0];
         end
      end
   end

   // Registered outputs; read data stand for exactly one cycle.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         rdata_o                      <= '0;
         crossover_algorithm_select_o <= spsc_pkg::RST_XOVER_ALG;
         port_indicator_zero_o        <= 1'b0;
         port_indicator_one_o         <= 1'b0;
         sa_filter_second_en_o        <= 1'b0;
         sa_filter_first_en_o         <= 1'b0;
         drop_tagged_o                <= 1'b0;
         irq_o                        <= 1'b0;
      end
      else
      begin
         rdata_o                      <= rd_i ? rdata_next : {DATA_W{1'b0}};
         crossover_algorithm_select_o <= xover_reg;
         port_indicator_zero_o        <= ind0_next;
         port_indicator_one_o         <= ind1_next;
         sa_filter_second_en_o        <= sa_second_reg;
         sa_filter_first_en_o         <= sa_first_reg;
         drop_tagged_o                <= drop_tag_reg;
         irq_o                        <= |(irq_stat_next & irq_en_reg);
      end
   end

   // The read checks below sample one edge after a read strobe, where the read
   // data stand; that is the only cycle in which the word is defined.

   // Writes to the status word leave every read-only bit as the pins say.
   a_ro_write_ignored : assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_state ##2 rd_i && hit_state |=> rdata_o[13:0] == $past(stat_sync))
      else $error("Status write altered read-only bits");

   // The link good status bit follows its synchronised pin on a read.
   a_status_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_LINK_GOOD] == $past(stat_sync[spsc_pkg::LS_LINK_GOOD]))
      else $error("Link good read mismatch");

   // Status bit 14 is read-only and always reads zero, whatever was written.
   a_reserved_zero : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_POLARITY + 1] == 1'b0)
      else $error("Reserved bit read nonzero");

   // Control bit 15 reads zero.
   a_ctrl_msb_zero : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_ctrl |=> rdata_o[15] == 1'b0)
      else $error("Control bit 15 read nonzero");

   // The reserved range returns zero.
   a_reserved_range : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && (addr_i == spsc_pkg::OFS_RESERVED_LO || addr_i == spsc_pkg::OFS_RESERVED_HI) |=> rdata_o == '0)
      else $error("Reserved range read nonzero");

   // A written crossover select appears on its output two cycles later.
   a_xover_follow : assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_state |-> ##2 crossover_algorithm_select_o == $past(wdata_i[15], 2))
      else $error("Crossover select did not follow write");

   // A forcing code drives both indicators from the code bits.
   a_led_force : assert property (@(posedge mclk_i) disable iff (rst_i)
      led_code_reg[2] |=> port_indicator_zero_o == $past(led_code_reg[0])
                          && port_indicator_one_o == $past(led_code_reg[1]))
      else $error("Indicator override wrong");

   // A non-forcing code passes the normal indicator drive.
   a_led_normal : assert property (@(posedge mclk_i) disable iff (rst_i)
      !led_code_reg[2] |=> port_indicator_zero_o == $past(normal_ind_zero_i))
      else $error("Normal indicator not passed");

   // Filter and drop enables follow a control write within two cycles.
   a_ctrl_enables : assert property (@(posedge mclk_i) disable iff (rst_i)
      wr_ctrl |-> ##2 sa_filter_second_en_o == $past(wdata_i[11], 2)
                    && sa_filter_first_en_o == $past(wdata_i[10], 2)
                    && drop_tagged_o == $past(wdata_i[9], 2))
      else $error("Control enables did not follow write");

   // An event is never lost to a simultaneous clear.
   a_set_wins : assert property (@(posedge mclk_i) disable iff (rst_i)
      |ev_now |=> (irq_stat_reg & $past(ev_now)) == $past(ev_now))
      else $error("Event lost");

   // Polarity bit follows its pin.
   a_polarity_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_POLARITY] == $past(stat_sync[spsc_pkg::LS_POLARITY]))
      else $error("Polarity read mismatch");

   // Transmit pause bit follows its pin.
   a_tx_pause_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_TX_PAUSE] == $past(stat_sync[spsc_pkg::LS_TX_PAUSE]))
      else $error("Transmit pause read mismatch");

   // Receive pause bit follows its pin.
   a_rx_pause_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_RX_PAUSE] == $past(stat_sync[spsc_pkg::LS_RX_PAUSE]))
      else $error("Receive pause read mismatch");

   // Speed bit follows its pin.
   a_speed_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_SPEED] == $past(stat_sync[spsc_pkg::LS_SPEED]))
      else $error("Speed read mismatch");

   // Duplex bit follows its pin.
   a_duplex_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_DUPLEX] == $past(stat_sync[spsc_pkg::LS_DUPLEX]))
      else $error("Duplex read mismatch");

   // Far-end fault bit follows its pin.
   a_far_fault_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_FAR_FAULT] == $past(stat_sync[spsc_pkg::LS_FAR_FAULT]))
      else $error("Far-end fault read mismatch");

   // Crossover state bit follows its pin.
   a_mdix_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_MDIX] == $past(stat_sync[spsc_pkg::LS_MDIX]))
      else $error("Crossover state read mismatch");

   // Negotiation done bit follows its pin.
   a_an_done_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_AN_DONE] == $past(stat_sync[spsc_pkg::LS_AN_DONE]))
      else $error("Negotiation done read mismatch");

   // Partner ability bits follow their pins.
   a_partner_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_PARTNER_HI:0] == $past(stat_sync[spsc_pkg::LS_PARTNER_HI:0]))
      else $error("Partner abilities read mismatch");

   // The stored algorithm select reads back in bit 15.
   a_xover_read : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_state |=> rdata_o[spsc_pkg::LS_XOVER_ALG] == $past(xover_reg))
      else $error("Crossover select read mismatch");

   // A non-forcing code passes the second normal indicator drive.
   a_led_normal_one : assert property (@(posedge mclk_i) disable iff (rst_i)
      !led_code_reg[2] |=> port_indicator_one_o == $past(normal_ind_one_i))
      else $error("Normal indicator one not passed");

   // The indicator code reads back in bits 14 to 12.
   a_ctrl_readback : assert property (@(posedge mclk_i) disable iff (rst_i)
      rd_i && hit_ctrl |=> rdata_o[spsc_pkg::CF_LED_HI:spsc_pkg::CF_LED_LO] == $past(led_code_reg))
      else $error("Indicator code read mismatch");

   // Read data are zero in every cycle not following a read strobe.
   a_rdata_idle : assert property (@(posedge mclk_i) disable iff (rst_i)
      !rd_i |=> rdata_o == '0)
      else $error("Read data outside read cycle");

   // Sticky bits only fall through a clear write.
   a_sticky_hold : assert property (@(posedge mclk_i) disable iff (rst_i)
      !wr_iclr |=> (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
      else $error("Sticky bit lost without clear");

endmodule

`default_nettype wire

// File: shared/spsc_pkg.sv
// Purpose: Shared constants for the switch port status and control register bank.
// Assumes: Plain register port with 16-bit data and byte offsets as printed.
// Notes:   Every offset and field position, and the crossover and indicator reset values, live here.
package spsc_pkg;

   // Register geometry.
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 16;

   // Register offsets.
   localparam logic [7:0]  OFS_LINK_STATE    = 8'h80;
   localparam logic [7:0]  OFS_RESERVED_LO   = 8'h82;
   localparam logic [7:0]  OFS_RESERVED_HI   = 8'h83;
   localparam logic [7:0]  OFS_CONTROL_FIRST = 8'h84;
   localparam logic [7:0]  OFS_IRQ_STATUS    = 8'hA0;
   localparam logic [7:0]  OFS_IRQ_ENABLE    = 8'hA2;
   localparam logic [7:0]  OFS_IRQ_CLEAR     = 8'hA4;

   // Link state field positions.
   localparam int          LS_XOVER_ALG      = 15;
   localparam int          LS_POLARITY       = 13;
   localparam int          LS_TX_PAUSE       = 12;
   localparam int          LS_RX_PAUSE       = 11;
   localparam int          LS_SPEED          = 10;
   localparam int          LS_DUPLEX         = 9;
   localparam int          LS_FAR_FAULT      = 8;
   localparam int          LS_MDIX           = 7;
   localparam int          LS_AN_DONE        = 6;
   localparam int          LS_LINK_GOOD      = 5;
   localparam int          LS_PARTNER_HI     = 4;

   // Control word field positions.
   localparam int          CF_LED_HI         = 14;
   localparam int          CF_LED_LO         = 12;
   localparam int          CF_SA_FILT_SECOND = 11;
   localparam int          CF_SA_FILT_FIRST  = 10;
   localparam int          CF_DROP_TAGGED    = 9;

   // Reset values.
   localparam logic        RST_XOVER_ALG     = 1'b1;
   localparam logic [2:0]  RST_LED_CODE      = 3'h0;

   // Interrupt event bit positions.
   localparam int          EV_LINK_CHANGE    = 0;
   localparam int          EV_AN_DONE        = 1;
   localparam int          EV_FAR_FAULT      = 2;
   localparam int          EV_COUNT          = 3;

endpackage

// File: logic/spsc_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of pin levels.
// Assumes: Inputs are quasi-static status levels from another domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module spsc_sync #(
   parameter int WIDTH = 16
) (
   // Clock and reset.
   input  wire logic             mclk_i,
   input  wire logic             rst_i,
   // Levels in and out.
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_reg;   // First stage, read only by the second.

   // Both stages clear on reset so status reads zero until sampled.
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         meta_reg <= '0;
         sync_o   <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the port one link state and port two control register bank.
// Assumes: Register reads return data one cycle after the strobe; status pins pass a two-stage sync.
// Notes:   Interrupt status, enable and clear registers are exercised through the same bus tasks.
`timescale 1ns/1ps
`default_nettype none

module tb_top;

   // Clock, reset and register port drive.
   logic        mclk_i;
   logic        rst_i;
   logic [7:0]  addr_r;
   logic [15:0] wdata_r;
   logic        wr_r;
   logic        rd_r;
   logic [15:0] rdata_o;
   // Status pin levels, index equals the status bit they feed.
   logic [13:0] pins;
   // Normal indicator levels from the mode logic.
   logic        norm_zero;
   logic        norm_one;
   // Observed control outputs.
   logic        xover_o;
   logic        ind_zero_o;
   logic        ind_one_o;
   logic        sa_second_o;
   logic        sa_first_o;
   logic        drop_o;
   logic        irq_o;
   // Scoreboard counters.
   int          error_cnt;
   int          cmp_count;
   logic [15:0] rd_val;

   spsc_regs u_dut (
      .mclk_i                       (mclk_i),
      .rst_i                        (rst_i),
      .addr_i                       (addr_r),
      .wdata_i                      (wdata_r),
      .wr_i                         (wr_r),
      .rd_i                         (rd_r),
      .rdata_o                      (rdata_o),
      .polarity_rev_i               (pins[13]),
      .tx_pause_act_i               (pins[12]),
      .rx_pause_act_i               (pins[11]),
      .speed_100_i                  (pins[10]),
      .full_duplex_i                (pins[9]),
      .far_fault_i                  (pins[8]),
      .mdix_state_i                 (pins[7]),
      .an_done_i                    (pins[6]),
      .link_good_i                  (pins[5]),
      .partner_abil_i               (pins[4:0]),
      .normal_ind_zero_i            (norm_zero),
      .normal_ind_one_i             (norm_one),
      .crossover_algorithm_select_o (xover_o),
      .port_indicator_zero_o        (ind_zero_o),
      .port_indicator_one_o         (ind_one_o),
      .sa_filter_second_en_o        (sa_second_o),
      .sa_filter_first_en_o         (sa_first_o),
      .drop_tagged_o                (drop_o),
      .irq_o                        (irq_o)
   );

   // Free-running 25 MHz clock.
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // Compare one value and report a difference at once.
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Print the verdict and stop; the single exit of the run.
   task automatic conclude();
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Let n edges pass and settle just after the last one.
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   // One-cycle write strobe beside address and data.
   task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      addr_r  <= a;
      wdata_r <= d;
      wr_r    <= 1'b1;
      @(posedge mclk_i);
      wr_r    <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the single cycle it stands.
   task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_r <= a;
      rd_r   <= 1'b1;
      @(posedge mclk_i);
      rd_r   <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // Reset values of both words and of every output.
   task automatic scn_reset_values();
      bus_read(8'h80, rd_val);
      check("status after reset", 16'h8000, rd_val);
      bus_read(8'h84, rd_val);
      check("control after reset", 16'h0000, rd_val);
      check("outputs after reset", 16'h0040,
            {9'h000, xover_o, sa_second_o, sa_first_o, drop_o, irq_o, ind_one_o, ind_zero_o});
   endtask

   // Walk a single one across every status pin; pins feed through a sync so wait a few edges.
   task automatic scn_status_walk();
      for (int i = 0; i < 14; i++)
      begin
         pins <= 14'h0001 << i;
         idle(5);
         bus_read(8'h80, rd_val);
         check("status walk", {2'b10, 14'h0001 << i}, rd_val);
      end
   endtask

   // Writes reach only the algorithm select bit; the link state stays as the pins say.
   task automatic scn_status_write();
      pins <= 14'h3FFF;
      idle(5);
      bus_write(8'h80, 16'h4000);
      bus_read(8'h80, rd_val);
      check("status after write", 16'h3FFF, rd_val);
      check("select output low", 16'h0000, {15'h0000, xover_o});
      pins <= 14'h0000;
      bus_write(8'h80, 16'hFFFF);
      idle(5);
      bus_read(8'h80, rd_val);
      check("status after set", 16'h8000, rd_val);
      check("select output high", 16'h0001, {15'h0000, xover_o});
   endtask

   // Every indicator code with normal levels chosen so each path is told apart.
   task automatic scn_control_codes();
      logic [2:0] c;
      for (int k = 0; k < 8; k++)
      begin
         c = k[2:0];
         norm_zero <= ~c[0];
         norm_one  <= ~c[1];
         bus_write(8'h84, {1'b1, c, c[0], c[1], c[2], 9'h1FF});
         idle(2);
         bus_read(8'h84, rd_val);
         check("control readback", {1'b0, c, c[0], c[1], c[2], 9'h000}, rd_val);
         check("filter and drop", {13'h0000, c[0], c[1], c[2]}, {13'h0000, sa_second_o, sa_first_o, drop_o});
         if (c[2])
            check("forced indicators", {14'h0000, c[1], c[0]}, {14'h0000, ind_one_o, ind_zero_o});
         else
            check("normal indicators", {14'h0000, ~c[1], ~c[0]}, {14'h0000, ind_one_o, ind_zero_o});
      end
   endtask

   // The gap after the status word and the clear register read back nothing.
   task automatic scn_reserved();
      bus_write(8'h82, 16'hFFFF);
      bus_write(8'h83, 16'hFFFF);
      bus_read(8'h82, rd_val);
      check("reserved low", 16'h0000, rd_val);
      bus_read(8'h83, rd_val);
      check("reserved high", 16'h0000, rd_val);
      bus_read(8'hA4, rd_val);
      check("clear reads zero", 16'h0000, rd_val);
   endtask

   // Link change raises the interrupt when enabled, stays quiet when masked, and clears.
   task automatic scn_interrupt();
      pins <= 14'h0020;
      idle(5);
      bus_read(8'hA0, rd_val);
      check("sticky events", 16'h0007, rd_val);
      bus_write(8'hA4, 16'h0007);
      bus_write(8'hA2, 16'h0001);
      idle(2);
      check("irq idle", 16'h0000, {15'h0000, irq_o});
      pins <= 14'h0000;
      idle(6);
      check("irq raised", 16'h0001, {15'h0000, irq_o});
      bus_read(8'hA0, rd_val);
      check("irq status", 16'h0001, rd_val);
      bus_write(8'hA4, 16'h0001);
      idle(3);
      check("irq cleared", 16'h0000, {15'h0000, irq_o});
      bus_write(8'hA2, 16'h0000);
      pins <= 14'h0020;
      idle(6);
      check("irq masked", 16'h0000, {15'h0000, irq_o});
      bus_read(8'hA0, rd_val);
      check("masked status", 16'h0001, rd_val);
      bus_write(8'hA2, 16'h0001);
      idle(3);
      check("irq unmasked", 16'h0001, {15'h0000, irq_o});
      bus_write(8'hA4, 16'h0001);
      idle(3);
      check("irq final", 16'h0000, {15'h0000, irq_o});
   endtask

   // Guard against a hang: running out of time counts as a mismatch.
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      conclude();
   end

   // Main sequence.
   initial
   begin
      error_cnt = 0;
      cmp_count = 0;
      rst_i     = 1'b1;
      addr_r    = 8'h00;
      wdata_r   = 16'h0000;
      wr_r      = 1'b0;
      rd_r      = 1'b0;
      pins      = 14'h0000;
      norm_zero = 1'b0;
      norm_one  = 1'b0;
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      idle(1);
      scn_reset_values();
      scn_status_walk();
      scn_status_write();
      scn_control_codes();
      scn_reserved();
      scn_interrupt();
      conclude();
   end

endmodule

`default_nettype wire
